// ### common/xpf_consts.svh
// Purpose: Constants for the data RAM page and FIFO window block
// Assumes: Included by its bare name
// Notes:   Offsets, fields, reset values and wait counts
`ifndef XPF_CONSTS_SVH
`define XPF_CONSTS_SVH

// Register offsets on the special register port
`define XPF_ADDR_PAGE   8'haa
`define XPF_ADDR_CFG    8'h85

// Field positions
`define XPF_PAGE_MSB    2
`define XPF_FAE_BIT     6

// Reset values and fixed read values
`define XPF_PAGE_RST    3'h0
`define XPF_FAE_RST     1'b0
`define XPF_CFG_FIXED   6'h03

// Window placement and RAM sizes
`define XPF_FIFO_HI     8'h04
`define XPF_DRAM_AW     10
`define XPF_FIFO_AW     8

// Extra wait cycles for a crossing into the usb clock side
`define XPF_FIFO_CYC    3'h4

`endif

// ### common/xpf_pkg.sv
// Purpose: Types for the data RAM page and FIFO window block
// Assumes: Used by xpf_top only
// Notes:   Constants live in xpf_consts.svh
`default_nettype none
package xpf_pkg;

  // Access sequencer states
  typedef enum logic [0:0] {
    XP_IDLE = 1'b0,
    XP_FIFO = 1'b1
  } xpf_st_e;

  // Whole control state of the block
  typedef struct packed {
    xpf_st_e    st;
    logic [2:0] cnt;
    logic [2:0] page;
    logic       fae;
    logic [7:0] sfr_rdata;
    logic [7:0] movx_rdata;
    logic       rvalid;
    logic       usb_m;
    logic       usb_s;
  } xpf_state_s;

endpackage : xpf_pkg
`default_nettype wire

// ### logic/xpf_top.sv
// Purpose: Data RAM page select and usb FIFO window for MOVX accesses
// Assumes: CPU holds request, address and data until ready is seen
// Notes:   FIFO side modelled by wait cycles gated on usb clock activity
`timescale 1ns/10ps
`default_nettype none
`include "xpf_consts.svh"

module xpf_top (
  // Clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // Special register port
  input  wire logic [7:0]  I_SFR_ADDR,
  input  wire logic        I_SFR_WR,
  input  wire logic        I_SFR_RD,
  input  wire logic [7:0]  I_SFR_WDATA,
  output logic      [7:0]  O_SFR_RDATA,
  // MOVX access port
  input  wire logic        I_MOVX_REQ,
  input  wire logic        I_MOVX_WE,
  input  wire logic        I_MOVX_WIDE,
  input  wire logic [15:0] I_MOVX_ADDR,
  input  wire logic [7:0]  I_MOVX_WDATA,
  output logic             O_MOVX_READY,
  output logic      [7:0]  O_MOVX_RDATA,
  output logic             O_MOVX_RVALID,
  // Usb clock activity level
  input  wire logic        I_USB_CLK_ACTIVE
);
  import xpf_pkg::*;

  xpf_state_s q;
  xpf_state_s d;
  xpf_state_s rst_val;

  // Memories carry no reset; unwritten bytes read unknown
  logic [7:0]  dram_mem [0:(1 << `XPF_DRAM_AW) - 1];
  logic [7:0]  fifo_mem [0:(1 << `XPF_FIFO_AW) - 1];
  logic [15:0] eff;
  logic        fifo_hit;
  logic        take;
  logic        take_fifo;
  logic [7:0]  sfr_mux;
  logic [9:0]  dram_idx;
  logic [7:0]  fifo_idx;

  // Reset image of the state
  always_comb begin
    // Fields not listed here reset to zero
    rst_val            = '0;
    rst_val.st         = XP_IDLE;
    rst_val.page       = `XPF_PAGE_RST;
    rst_val.fae        = `XPF_FAE_RST;
  end

  // Effective address and window decode
  always_comb begin
    if (I_MOVX_WIDE) begin
      eff = I_MOVX_ADDR;
    end else begin
      eff = {5'h00, q.page, I_MOVX_ADDR[7:0]};
    end
    fifo_hit = q.fae && (eff[15:8] == `XPF_FIFO_HI);
    dram_idx = eff[9:0];
    fifo_idx = eff[7:0];
  end

  // Ready: plain RAM at once, window after the wait with usb running
  // Dropping the request mid-wait abandons the window access
  always_comb begin
    O_MOVX_READY = I_MOVX_REQ &&
                   (((q.st == XP_IDLE) && !fifo_hit) ||
                    ((q.st == XP_FIFO) && fifo_hit &&
                     (q.cnt == 3'h0) && q.usb_s));
    take      = O_MOVX_READY;
    take_fifo = O_MOVX_READY && (q.st == XP_FIFO);
  end

  // Register read mux
  // Unmapped addresses read zero, writes there change nothing
  always_comb begin
    if (I_SFR_ADDR == `XPF_ADDR_PAGE) begin
      sfr_mux = {5'h00, q.page};
    end else if (I_SFR_ADDR == `XPF_ADDR_CFG) begin
      sfr_mux = {1'b0, q.fae, `XPF_CFG_FIXED};
    end else begin
      sfr_mux = 8'h00;
    end
  end

  // Next state
  always_comb begin
    d        = q;
    // Two flops on the usb activity level; only the second is read
    d.usb_m  = I_USB_CLK_ACTIVE;
    d.usb_s  = q.usb_m;
    d.rvalid = 1'b0;
    // Register writes, only the writable fields change
    if (I_SFR_WR && (I_SFR_ADDR == `XPF_ADDR_PAGE)) begin
      d.page = I_SFR_WDATA[`XPF_PAGE_MSB:0];
    end
    if (I_SFR_WR && (I_SFR_ADDR == `XPF_ADDR_CFG)) begin
      d.fae = I_SFR_WDATA[`XPF_FAE_BIT];
    end
    if (I_SFR_RD) begin
      d.sfr_rdata = sfr_mux;
    end
    // Access sequencer
    // Wait count only moves while the usb side runs
    unique case (q.st)
      XP_IDLE: begin
        if (I_MOVX_REQ && fifo_hit) begin
          d.st  = XP_FIFO;
          d.cnt = `XPF_FIFO_CYC;
        end
      end
      XP_FIFO: begin
        if (!I_MOVX_REQ || !fifo_hit) begin
          d.st = XP_IDLE;
        end else if (q.usb_s) begin
          if (q.cnt != 3'h0) begin
            d.cnt = q.cnt - 3'h1;
          end else begin
            d.st = XP_IDLE;
          end
        end
      end
    endcase
    // Read data capture
    if (take && !I_MOVX_WE) begin
      d.rvalid = 1'b1;
      if (take_fifo) begin
        d.movx_rdata = fifo_mem[fifo_idx];
      end else begin
        d.movx_rdata = dram_mem[dram_idx];
      end
    end
  end

  // State register
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  // Memory writes, no reset on contents
  // Only a taken edge writes, so an abandoned request leaves memory alone
  always_ff @(posedge I_CORE_CLK) begin
    if (take && I_MOVX_WE && take_fifo) begin
      fifo_mem[fifo_idx] <= I_MOVX_WDATA;
    end
    if (take && I_MOVX_WE && !take_fifo) begin
      dram_mem[dram_idx] <= I_MOVX_WDATA;
    end
  end

  // Outputs
  assign O_SFR_RDATA   = q.sfr_rdata;
  assign O_MOVX_RDATA  = q.movx_rdata;
  assign O_MOVX_RVALID = q.rvalid;

  // Checks
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_PAGE_HIGH_ZERO:
    assert property ((I_SFR_RD && I_SFR_ADDR == `XPF_ADDR_PAGE)
                     |=> (O_SFR_RDATA[7:3] == 5'h00))
    else $error("page register upper bits not zero");

  AST_PAGE_WRITE_KEEPS:
    assert property ((I_SFR_WR && I_SFR_ADDR == `XPF_ADDR_PAGE)
                     |=> (q.page == $past(I_SFR_WDATA[2:0])))
    else $error("page field not loaded");

  AST_NARROW_HIGH_BYTE:
    assert property ((take && !I_MOVX_WIDE && !take_fifo)
                     |-> (dram_idx == {q.page[1:0], I_MOVX_ADDR[7:0]}))
    else $error("narrow access ignores page");

  AST_CFG_ENABLE_READ:
    assert property ((I_SFR_RD && I_SFR_ADDR == `XPF_ADDR_CFG)
                     |=> (O_SFR_RDATA[6] == $past(q.fae)))
    else $error("enable bit read wrong");

  AST_CFG_BIT7:
    assert property ((I_SFR_RD && I_SFR_ADDR == `XPF_ADDR_CFG)
                     |=> !O_SFR_RDATA[7])
    else $error("config bit 7 not zero");

  AST_CFG_FIXED:
    assert property ((I_SFR_RD && I_SFR_ADDR == `XPF_ADDR_CFG)
                     |=> (O_SFR_RDATA[5:0] == 6'h03))
    else $error("config low bits wrong");

  AST_WINDOW_STALLS:
    assert property ((q.st == XP_IDLE && I_MOVX_REQ && fifo_hit)
                     |-> !O_MOVX_READY ##1 !O_MOVX_READY[*4])
    else $error("window access too fast");

  AST_WINDOW_NEEDS_USB:
    assert property ((q.st == XP_FIFO && !q.usb_s) |-> !O_MOVX_READY)
    else $error("window answered without usb clock");

  AST_WINDOW_HIDES_RAM:
    assert property ((take && q.fae && eff[15:8] == 8'h04) |-> take_fifo)
    else $error("normal RAM reached inside window");

  AST_NO_FIFO_WHEN_OFF:
    assert property ((q.st == XP_IDLE && I_MOVX_REQ && !q.fae)
                     |-> O_MOVX_READY ##1 (q.st == XP_IDLE))
    else $error("disabled window stalled or entered FIFO");

  AST_WINDOW_MAP:
    assert property (take_fifo |-> (q.fae && eff[15:8] == 8'h04))
    else $error("FIFO reached outside window");

  AST_WIDE_WRAP:
    assert property ((take && I_MOVX_WIDE && !take_fifo)
                     |-> (dram_idx == I_MOVX_ADDR[9:0]))
    else $error("wide address not wrapped");

  AST_HOLD_UNTIL_DONE:
    assert property ((q.st == XP_FIFO && I_MOVX_REQ && fifo_hit && q.usb_s)
                     [*5] |-> O_MOVX_READY)
    else $error("window access never completed");

  // Reset image and register field checks
  AST_RESET_IMAGE:
    assert property ($rose(I_RST_N)
                     |-> (!q.fae && q.page == 3'h0 && q.st == XP_IDLE && !O_MOVX_RVALID))
    else $error("state not at reset image after release");

  AST_CFG_ENABLE_WRITE:
    assert property ((I_SFR_WR && I_SFR_ADDR == `XPF_ADDR_CFG)
                     |=> (q.fae == $past(I_SFR_WDATA[`XPF_FAE_BIT])))
    else $error("enable bit not loaded");

  AST_CFG_ENABLE_HOLDS:
    assert property (!(I_SFR_WR && I_SFR_ADDR == `XPF_ADDR_CFG)
                     |=> $stable(q.fae))
    else $error("enable bit changed without a write");

  AST_PAGE_HOLDS:
    assert property (!(I_SFR_WR && I_SFR_ADDR == `XPF_ADDR_PAGE)
                     |=> $stable(q.page))
    else $error("page field changed without a write");

  // Window decode seen from the access port
  AST_NARROW_PAGE_WINDOW:
    assert property ((take && !I_MOVX_WIDE && q.fae && q.page == 3'h4) |-> take_fifo)
    else $error("narrow access with page 4 missed the window");

  AST_WIDE_WINDOW:
    assert property ((take && I_MOVX_WIDE && q.fae && I_MOVX_ADDR[15:8] == 8'h04)
                     |-> take_fifo)
    else $error("wide access inside window missed the FIFO");

  AST_OUTSIDE_NO_WAIT:
    assert property ((q.st == XP_IDLE && I_MOVX_REQ && q.fae && I_MOVX_WIDE &&
                      I_MOVX_ADDR[15:8] != 8'h04) |-> O_MOVX_READY)
    else $error("access outside window was stalled");

  // Read data return
  AST_READ_RETURNS:
    assert property ((take && !I_MOVX_WE) |=> O_MOVX_RVALID)
    else $error("read data not returned after take");

  AST_WRITE_NO_DATA:
    assert property ((take && I_MOVX_WE) |=> !O_MOVX_RVALID)
    else $error("read valid after a write");

  COV_NARROW: cover property (take && !I_MOVX_WIDE && !take_fifo);
  COV_FIFO_READ: cover property (take_fifo && !I_MOVX_WE ##1 O_MOVX_RVALID);
  COV_WIDE_WRAP: cover property (take && I_MOVX_WIDE && I_MOVX_ADDR[15:10] != 6'h00);
  COV_USB_STALL: cover property (q.st == XP_FIFO && !q.usb_s);
  COV_WINDOW_WRITE: cover property (take_fifo && I_MOVX_WE);

endmodule : xpf_top
`default_nettype wire

// ### test/test_xpf_top.sv
// Purpose: Self-checking bench for xpf_top
// Assumes: CPU model drives the MOVX port
// Notes:   Seeded random traffic plus window corners
`timescale 1ns/10ps
`default_nettype none
`include "xpf_consts.svh"
module test_xpf_top;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, we = 0, wide = 0;
  logic        usb = 1; // Usb clock running unless a movx stall holds it idle
  logic [7:0]  sa = 0, sd = 0, cd = 0, srd, mrd, rb, cyc, mwd, d, r, drd;
  logic [15:0] a = 0, ma, t;
  logic        req, mwe, mwide, rdy, rv, done;
  int          failures = 0, checks_done = 0, seed = 66974, i;
  // Core clock
  initial forever #2.5 clk = ~clk;
  xpf_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(sa), .I_SFR_WR(wr),
    .I_SFR_RD(rd), .I_SFR_WDATA(sd), .O_SFR_RDATA(srd), .I_MOVX_REQ(req),
    .I_MOVX_WE(mwe), .I_MOVX_WIDE(mwide), .I_MOVX_ADDR(ma), .I_MOVX_WDATA(mwd),
    .O_MOVX_READY(rdy), .O_MOVX_RDATA(drd), .O_MOVX_RVALID(rv), .I_USB_CLK_ACTIVE(usb));
  xpf_cpu_model cpu (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_we(we), .i_wide(wide),
    .i_addr(a), .i_wdata(cd), .i_ready(rdy), .i_rvalid(rv), .i_rdata(drd), .o_req(req),
    .o_we(mwe), .o_wide(mwide), .o_addr(ma), .o_wdata(mwd), .o_done(done), .o_rd(mrd),
    .o_cyc(cyc));
  // Compare and count
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Expected config read for a given enable value
  function automatic logic [7:0] cfg_exp(logic en);
    return {1'b0, en, `XPF_CFG_FIXED};
  endfunction : cfg_exp
  // Verdict
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Register write or read, read data into rb
  task automatic sfr(logic w, logic [7:0] ad, logic [7:0] dt);
    @(posedge clk);
    {sa, sd, wr, rd} <= {ad, dt, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1 rb = srd;
  endtask : sfr
  // One MOVX access, usb held idle for st + 1 cycles when st is above zero
  task automatic movx(logic w, logic wd, logic [15:0] ad, logic [7:0] dt, int st);
    @(posedge clk);
    {we, wide, a, cd, go} <= {w, wd, ad, dt, 1'b1};
    if (st > 0) usb <= 1'b0;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 300 && done !== 1'b1; k++) begin
      if (k == st) usb <= 1'b1;
      @(posedge clk);
    end
    if (done !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask : movx
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sfr(0, `XPF_ADDR_CFG, 0);
    check("cfg_rst", rb, cfg_exp(1'b0));
    sfr(1, `XPF_ADDR_PAGE, 8'hff);
    sfr(0, `XPF_ADDR_PAGE, 0);
    check("page_ro", rb, 8'h07);
    sfr(1, `XPF_ADDR_CFG, 8'hff);
    sfr(0, `XPF_ADDR_CFG, 0);
    check("cfg_rw", rb, cfg_exp(1'b1));
    sfr(1, `XPF_ADDR_CFG, 8'h00);
    sfr(0, 8'h86, 0);
    check("unmapped", rb, 8'h00);
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      t = 16'($random(seed));
      movx(1, 1, t, d, 0);
      check("plain_cyc", cyc, 8'h01);
      movx(0, 1, t ^ (16'($random(seed)) << 10), 0, 0);
      check("alias_rd", mrd, d);
      sfr(1, `XPF_ADDR_PAGE, {5'h0, 1'($random(seed)), t[9:8]});
      movx(0, 0, {8'($random(seed)), t[7:0]}, 0, 0);
      check("page_rd", mrd, d);
    end
    r = 8'($random(seed));
    d = ~r;
    movx(1, 1, 16'h0055, r, 0);
    sfr(1, `XPF_ADDR_CFG, 8'h40);
    movx(1, 1, 16'h0455, d, 0);
    check("win_cyc", {7'h0, cyc > 8'h05}, 8'h01);
    sfr(1, `XPF_ADDR_PAGE, 8'h04);
    movx(0, 0, 16'h0055, 0, 0);
    check("win_rd", mrd, d);
    movx(0, 1, 16'h0055, 0, 0);
    check("ram_kept", mrd, r);
    movx(0, 1, 16'h0455, 0, 20);
    check("stall_rd", mrd, d);
    check("stall_cyc", {7'h0, cyc > 8'd20}, 8'h01);
    sfr(1, `XPF_ADDR_CFG, 8'h00);
    movx(0, 1, 16'h0455, 0, 0);
    check("win_off", mrd, r);
    end_sim();
  end
endmodule : test_xpf_top
`default_nettype wire

// ### test/xpf_cpu_model.sv
// Purpose: CPU model issuing MOVX accesses
// Assumes: Bench pulses i_go with a command
// Notes:   Idle address and data lines show inverted last value
`timescale 1ns/10ps
`default_nettype none
module xpf_cpu_model (
  // Clock, reset and command
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic        i_we,
  input  wire logic        i_wide,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  // Device answer
  input  wire logic        i_ready,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_rdata,
  // Request lines
  output logic             o_req,
  output logic             o_we,
  output logic             o_wide,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata,
  // Results
  output logic             o_done,
  output logic      [7:0]  o_rd,
  output logic      [7:0]  o_cyc
);
  logic wait_q;
  // Hold request until ready; no packet data touched
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      o_req <= 1'b0;
      wait_q <= 1'b0;
      {o_we, o_wide, o_addr, o_wdata} <= '0;
    end else if (i_go && !o_req && !wait_q) begin
      {o_req, o_we, o_wide, o_addr, o_wdata} <= {1'b1, i_we, i_wide, i_addr, i_wdata};
      o_cyc <= 8'h01;
    end else if (o_req && i_ready) begin
      o_req <= 1'b0;
      wait_q <= !o_we;
      o_done <= o_we;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
    end else if (o_req) begin
      o_cyc <= o_cyc + 8'h01;
    end else if (wait_q && i_rvalid) begin
      wait_q <= 1'b0;
      o_rd <= i_rdata;
      o_done <= 1'b1;
    end
  end
endmodule : xpf_cpu_model
`default_nettype wire
